// ---- design/scec_map.vh ----
// Register offsets, field positions, reset values and constants of the supply chip enable control.
`ifndef SCEC_MAP_VH
`define SCEC_MAP_VH
`define SCEC_CTL_ADDR        8'h00
`define SCEC_WAKE_ADDR       8'h04
`define SCEC_STAT_ADDR       8'h08
`define SCEC_SCRATCH_BASE    8'h40
`define SCEC_SCRATCH_LAST    8'h7c
`define SCEC_KEY_LSB         0
`define SCEC_KEY_MSB         7
`define SCEC_POL_BIT         16
`define SCEC_DRIVE_BIT       28
`define SCEC_ALWAYS_BIT      29
`define SCEC_EN_BIT          31
`define SCEC_UNLOCK_KEY      8'h3a
`define SCEC_KEY_RST         8'h00
`define SCEC_POL_RST         1'b1
`define SCEC_DRIVE_RST       1'b1
`define SCEC_EN_RST          1'b1
`define SCEC_WAKE_ALARM_BIT  0
`define SCEC_WAKE_CENT_BIT   1
`define SCEC_WAKE_PIN_BIT    2
`define SCEC_SCRATCH_COUNT   16
`define SCEC_RESP_OKAY       2'b00
`define SCEC_RESP_SLVERR     2'b10
`define SCEC_YEAR_LAST       7'd99
`define SCEC_YEAR_FIRST      7'd0
`endif

// ---- design/scec_supply_chip_enable_control.v ----
// Supply chip enable control with unlock key, retained scratch words and an AXI4-Lite slave.
// Notes on behaviour
// RULE1 - Enable pin is active high, held while powered.
// RULE2 - Backup reset brings the enable high again.
// RULE3 - Enable writes ignored unless key holds 3a.
// RULE4 - Software changes key and enable separately.
// RULE5 - Software keeps the polarity bit at one.
// RULE6 - Drive bit zero floats pin only when unlocked.
// RULE7 - Override forces enable, ignores enable and drive.
// RULE8 - Override sets once, clears only by reset.
// RULE9 - Enable bit resets to enabled.
// RULE10 - Enable clears only with earlier key, no override.
// RULE11 - Software writes settings first, then new bits.
// RULE12 - Clearing enable turns supply off, may re-set.
// RULE13 - Alarm or century event re-enables the supply.
// RULE14 - High wake pin enables supply when polarity one.
// RULE15 - Wake pin also leaves hibernate.
// RULE16 - Sixteen retained 32-bit scratch words.
// RULE17 - Scratch words survive hibernate.
// RULE18 - Century event on year rollover 99 to 00.
// RULE19 - Hardware wake sets enable regardless of key.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "scec_map.vh"
module scec_supply_chip_enable_control
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        clk_en,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        alarm_event,
   input  wire        hibernate_active,
   input  wire [6:0]  calendar_year,
   input  wire        external_wake_pin,
   output reg         supply_enable_pin_o,
   output reg         supply_enable_pin_oe_n,
   output reg         hibernate_wake
);

   reg  [7:0]  key_q;
   reg         polarity_q;
   reg         enable_pin_drive_bit_q;
   reg         always_on_override_q;
   reg         supply_chip_enable_bit_q;
   reg  [2:0]  wake_seen_q;
   reg  [31:0] retained_scratch_word [0:`SCEC_SCRATCH_COUNT-1];
   reg  [6:0]  year_q;
   reg         year_valid_q;
   reg         wake_meta_q;
   reg         wake_sync_q;
   reg         alarm_meta_q;
   reg         alarm_sync_q;
   reg         alarm_prev_q;
   reg         hib_meta_q;
   reg         hib_sync_q;
   reg  [7:0]  aw_addr_q;
   reg         aw_have_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   reg         w_have_q;

   wire        wr_go;
   wire [31:0] wmask;
   wire [31:0] ctl_new;
   wire        unlocked;
   wire        century_evt;
   wire        alarm_evt;
   wire        pin_wake;
   wire        hw_wake;
   wire        wr_ctl;
   wire        wr_wake;
   wire        wr_scratch;
   wire [3:0]  wr_idx;
   wire [3:0]  rd_idx;
   reg  [31:0] ctl_read;
   reg  [31:0] rd_word;
   reg  [1:0]  rd_resp;
   reg  [1:0]  wr_resp;

   assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   assign ctl_new = (w_data_q & wmask) | (ctl_read & ~wmask);
   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr_ctl = wr_go && (aw_addr_q == `SCEC_CTL_ADDR);
   assign wr_wake = wr_go && (aw_addr_q == `SCEC_WAKE_ADDR);
   assign wr_scratch = wr_go && (aw_addr_q[7:6] == 2'b01) && (aw_addr_q[1:0] == 2'b00);
   assign wr_idx = aw_addr_q[5:2];
   assign rd_idx = s_axi_araddr[5:2];
   // Only the stored key counts, so a write carrying the key cannot also clear the enable.
   assign unlocked = (key_q == `SCEC_UNLOCK_KEY); // [RULE3] [RULE10]
   // The year rollover is seen only after one valid sample, so reset cannot fake a century.
   assign century_evt = year_valid_q && (year_q == `SCEC_YEAR_LAST) &&
                        (calendar_year == `SCEC_YEAR_FIRST); // [RULE18]
   assign alarm_evt = alarm_sync_q && !alarm_prev_q;
   assign pin_wake = wake_sync_q && polarity_q; // [RULE14]
   assign hw_wake = alarm_evt || century_evt || pin_wake; // [RULE13]

   always @*
   begin
      ctl_read = 32'h00000000;
      ctl_read[`SCEC_KEY_MSB:`SCEC_KEY_LSB] = key_q;
      ctl_read[`SCEC_POL_BIT] = polarity_q;
      ctl_read[`SCEC_DRIVE_BIT] = enable_pin_drive_bit_q;
      ctl_read[`SCEC_ALWAYS_BIT] = always_on_override_q;
      ctl_read[`SCEC_EN_BIT] = supply_chip_enable_bit_q;
   end

   always @*
   begin
      rd_word = 32'h00000000;
      rd_resp = `SCEC_RESP_OKAY;
      if (s_axi_araddr == `SCEC_CTL_ADDR)
         rd_word = ctl_read;
      else if (s_axi_araddr == `SCEC_WAKE_ADDR)
         rd_word = {29'h00000000, wake_seen_q};
      else if (s_axi_araddr == `SCEC_STAT_ADDR)
         rd_word = {22'h000000, unlocked, hib_sync_q, year_q, supply_enable_pin_o};
      else if ((s_axi_araddr[7:6] == 2'b01) && (s_axi_araddr[1:0] == 2'b00))
         rd_word = retained_scratch_word[rd_idx];
      else
         rd_resp = `SCEC_RESP_SLVERR;
   end

   always @*
   begin
      wr_resp = `SCEC_RESP_OKAY;
      if (!(wr_ctl || wr_wake || wr_scratch || aw_addr_q == `SCEC_STAT_ADDR))
         wr_resp = `SCEC_RESP_SLVERR;
   end

   // Synchronisers for pins from outside the clock domain.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wake_meta_q <= 1'b0;
         wake_sync_q <= 1'b0;
         alarm_meta_q <= 1'b0;
         alarm_sync_q <= 1'b0;
         alarm_prev_q <= 1'b0;
         hib_meta_q <= 1'b0;
         hib_sync_q <= 1'b0;
         year_q <= 7'd0;
         year_valid_q <= 1'b0;
      end
      else if (clk_en)
      begin
         wake_meta_q <= external_wake_pin;
         wake_sync_q <= wake_meta_q;
         alarm_meta_q <= alarm_event;
         alarm_sync_q <= alarm_meta_q;
         alarm_prev_q <= alarm_sync_q;
         hib_meta_q <= hibernate_active;
         hib_sync_q <= hib_meta_q;
         year_q <= calendar_year;
         year_valid_q <= 1'b1;
      end
   end

   // Control register; this reset stands for the backup domain reset only.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         key_q <= `SCEC_KEY_RST;
         polarity_q <= `SCEC_POL_RST;
         enable_pin_drive_bit_q <= `SCEC_DRIVE_RST;
         always_on_override_q <= 1'b0; // [RULE8]
         supply_chip_enable_bit_q <= `SCEC_EN_RST; // [RULE2] [RULE9]
         wake_seen_q <= 3'b000;
      end
      else if (clk_en)
      begin
         if (wr_ctl)
         begin
            key_q <= ctl_new[`SCEC_KEY_MSB:`SCEC_KEY_LSB];
            polarity_q <= ctl_new[`SCEC_POL_BIT];
            enable_pin_drive_bit_q <= ctl_new[`SCEC_DRIVE_BIT];
            if (ctl_new[`SCEC_ALWAYS_BIT])
               always_on_override_q <= 1'b1; // [RULE8]
         end
         // Wake events win over a clearing write in the same cycle.
         if (hw_wake || always_on_override_q)
            supply_chip_enable_bit_q <= 1'b1; // [RULE7] [RULE19] [RULE13]
         else if (wr_ctl && unlocked && !ctl_new[`SCEC_ALWAYS_BIT])
            supply_chip_enable_bit_q <= ctl_new[`SCEC_EN_BIT]; // [RULE10] [RULE12]
         // Sticky wake causes: set wins over a write-one-to-clear.
         wake_seen_q <= (wake_seen_q & ~({3{wr_wake && w_strb_q[0]}} & w_data_q[2:0])) |
                        {pin_wake, century_evt, alarm_evt};
      end
   end

   // Scratch words are never touched by reset and so persist through hibernate.
   genvar gi;
   generate
      for (gi = 0; gi < `SCEC_SCRATCH_COUNT; gi = gi + 1)
      begin : g_scratch
         always @(posedge aclk)
         begin
            if (clk_en && wr_scratch && (wr_idx == gi))
               retained_scratch_word[gi] <= ctl_new_scr(retained_scratch_word[gi]); // [RULE16] [RULE17]
         end
      end
   endgenerate

   function [31:0] ctl_new_scr;
      input [31:0] old;
      begin
         ctl_new_scr = (w_data_q & wmask) | (old & ~wmask);
      end
   endfunction

   // Pin drive: the override forces the pin driven high; floating needs the key.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         supply_enable_pin_o <= 1'b1; // [RULE2]
         supply_enable_pin_oe_n <= 1'b0;
         hibernate_wake <= 1'b0;
      end
      else if (clk_en)
      begin
         supply_enable_pin_o <= supply_chip_enable_bit_q || always_on_override_q; // [RULE1] [RULE7]
         supply_enable_pin_oe_n <= !always_on_override_q && !enable_pin_drive_bit_q &&
                                   unlocked; // [RULE6]
         hibernate_wake <= wake_sync_q && hib_sync_q; // [RULE15]
      end
   end

   // AXI4-Lite slave: address and data are taken in either order, one of each.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SCEC_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SCEC_RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_resp;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_resp;
         end
         if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// ---- testbench/scec_pmic_model.sv ----
// Model of the external supply chip enable input fed by the enable pin.
`timescale 1ns/100ps
module scec_pmic_model
(
   input  wire aclk,
   input  wire pin_o,
   input  wire pin_oe_n,
   output reg  chip_on_q
);
   // A released pin shows the inverse of its last level, so a float never passes as a value.
   reg  last_q = 1'b1;
   wire level = pin_oe_n ? ~last_q : pin_o;
   always @(posedge aclk)
   begin
      if (!pin_oe_n)
         last_q <= pin_o;
      chip_on_q <= level;
   end
endmodule

// ---- testbench/scec_assertions.sv ----
// Port-level assertions for the supply chip enable control.
`timescale 1ns/100ps
module scec_assertions
(
   input wire       aclk,
   input wire       aresetn,
   input wire       clk_en,
   input wire       s_axi_bvalid,
   input wire       alarm_event,
   input wire [6:0] calendar_year,
   input wire       external_wake_pin,
   input wire       hibernate_active,
   input wire       supply_enable_pin_o,
   input wire       supply_enable_pin_oe_n,
   input wire       hibernate_wake
);
   default clocking cb @(posedge aclk);
   endclocking
   // A frozen clock enable stalls the synchronisers, so timed wake checks pause with it.
   default disable iff (!aresetn || !clk_en);
   chk_reset_pin: assert property (disable iff (1'b0) !aresetn |=> supply_enable_pin_o)
      else $error("enable pin low after reset");
   chk_pin_held: assert property (supply_enable_pin_o && !s_axi_bvalid |=> supply_enable_pin_o)
      else $error("enable pin dropped without a write");
   chk_clear_write: assert property ($fell(supply_enable_pin_o) |-> $past(s_axi_bvalid))
      else $error("enable cleared outside a write");
   chk_float_write: assert property ($rose(supply_enable_pin_oe_n) |-> $past(s_axi_bvalid))
      else $error("pin released outside a write");
   chk_alarm_wake: assert property ($rose(alarm_event) |-> ##[1:8] supply_enable_pin_o)
      else $error("alarm did not enable the supply");
   chk_century_wake: assert property (calendar_year == 7'd99 ##1 calendar_year == 7'd0
      |-> ##[1:4] supply_enable_pin_o) else $error("century did not enable the supply");
   chk_pin_wake: assert property (external_wake_pin [*4] |-> ##[0:4] supply_enable_pin_o)
      else $error("wake pin did not enable the supply");
   chk_hib_wake: assert property ((hibernate_active && external_wake_pin) [*4]
      |-> ##[0:4] hibernate_wake) else $error("wake pin did not leave hibernate");
endmodule
bind scec_supply_chip_enable_control scec_assertions u_chk (.*);

// ---- testbench/test_supply_chip_enable_control.sv ----
// Self-checking bench for the supply chip enable control.
`timescale 1ns/100ps
`include "scec_map.vh"
module test_supply_chip_enable_control;
   reg         aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, s_axi_bready = 1'b1;
   reg         s_axi_rready = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   reg         s_axi_arvalid = 1'b0, alarm_event = 1'b0;
   reg         hibernate_active = 1'b0, external_wake_pin = 1'b0;
   reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'hf;
   reg  [6:0]  calendar_year = 7'd99;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire        hibernate_wake, supply_enable_pin_o, supply_enable_pin_oe_n, chip_on;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [2:0]  pins = {supply_enable_pin_o, supply_enable_pin_oe_n, chip_on};
   reg  [33:0] v;
   reg  [1:0]  b;
   reg  [78:0] rows [0:8];
   integer     failures = 0, n_tests = 0, i, k;
   scec_supply_chip_enable_control DUT (.*);
   scec_pmic_model PMIC (.aclk(aclk), .pin_o(supply_enable_pin_o),
      .pin_oe_n(supply_enable_pin_oe_n), .chip_on_q(chip_on));
   initial
      forever #25 aclk = ~aclk;
   task chk(input [38:0] s, input [38:0] e);
      begin
         n_tests = n_tests + 1;
         if (s !== e)
         begin
            failures = failures + 1;
            $display("Error at %0t: got %h expected %h", $time, s, e);
         end
      end
   endtask
   task test_done;
      begin
         $display("Checks %0d, mismatches %0d", n_tests, failures);
         if (failures == 0 && n_tests > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         do
         begin
            @(posedge aclk);
            if (s_axi_awready)
               s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
               s_axi_wvalid <= 1'b0;
         end
         while (s_axi_awvalid || s_axi_wvalid);
         do @(posedge aclk); while (!s_axi_bvalid);
         b = s_axi_bresp;
      end
   endtask
   task rd(input [7:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         do @(posedge aclk); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         do @(posedge aclk); while (!s_axi_rvalid);
         v = {s_axi_rresp, s_axi_rdata};
      end
   endtask
   initial
   begin
      // Polarity stays one; key and enable never move in one write.
      rows[0] = {8'h00, 32'h1001_0000, 4'h0, 32'h9001_0000, 3'b101};
      rows[1] = {8'h00, 32'h9001_003a, 4'h0, 32'h9001_003a, 3'b101};
      rows[2] = {8'h00, 32'h1001_003a, 4'h0, 32'h1001_003a, 3'b000};
      rows[3] = {8'h00, 32'h9001_003a, 4'h0, 32'h9001_003a, 3'b101};
      rows[4] = {8'h00, 32'h8001_003a, 4'h0, 32'h8001_003a, 3'b110};
      rows[5] = {8'h00, 32'h8001_0000, 4'h0, 32'h8001_0000, 3'b101};
      rows[6] = {8'h00, 32'h8001_003a, 4'h0, 32'h8001_003a, 3'b110};
      rows[7] = {8'h00, 32'h9001_003a, 4'h0, 32'h9001_003a, 3'b101};
      rows[8] = {8'h20, 32'h0000_0000, 4'ha, 32'h0000_0000, 3'b101};
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      chk({36'h0, pins}, {36'h0, 3'b101});
      for (i = 0; i < 9; i = i + 1)
      begin
         wr(rows[i][78:71], rows[i][70:39]);
         rd(rows[i][78:71]);
         chk({b, v, pins}, rows[i][38:0]);
      end
      for (k = 0; k < 3; k = k + 1)
      begin
         wr(8'h00, 32'h1001_003a);
         @(posedge aclk);
         chk({38'h0, supply_enable_pin_o}, 39'h0);
         alarm_event <= (k == 0);
         calendar_year <= (k == 1) ? 7'd0 : 7'd99;
         external_wake_pin <= (k == 2);
         hibernate_active <= (k == 2);
         for (i = 0; i < 20 && !supply_enable_pin_o; i = i + 1)
            @(posedge aclk);
         repeat (4) @(posedge aclk);
         rd(8'h00);
         chk({1'b0, hibernate_wake, v, pins}, {1'b0, k == 2, 34'h0_9001_003a, 3'b101});
         alarm_event <= 1'b0;
         external_wake_pin <= 1'b0;
         hibernate_active <= 1'b0;
      end
      wr(8'h00, 32'hb001_003a);
      wr(8'h00, 32'h0001_003a);
      rd(8'h00);
      chk({34'h0, v[31], v[29], pins}, {34'h0, 5'b11101});
      rd(8'h04);
      chk({5'h0, v}, {7'h0, 32'h0000_0007});
      wr(8'h04, 32'h0000_0005);
      rd(8'h04);
      chk({3'h0, b, v}, {7'h0, 32'h0000_0002});
      wr(8'h08, 32'h0000_0000);
      rd(8'h08);
      chk({3'h0, b, v}, {7'h0, 32'h0000_02c7});
      for (i = 0; i < 16; i = i + 1)
         wr(`SCEC_SCRATCH_BASE + {i[5:0], 2'b00}, {28'h5a5a5a5, i[3:0]});
      hibernate_active <= 1'b1;
      for (i = 0; i < 16; i = i + 1)
      begin
         rd(`SCEC_SCRATCH_BASE + {i[5:0], 2'b00});
         chk({5'h0, v}, {7'h0, 28'h5a5a5a5, i[3:0]});
      end
      clk_en <= 1'b0;
      external_wake_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      chk({38'h0, hibernate_wake}, 39'h0);
      clk_en <= 1'b1;
      repeat (6) @(posedge aclk);
      chk({38'h0, hibernate_wake}, {38'h0, 1'b1});
      external_wake_pin <= 1'b0;
      aresetn <= 1'b0;
      hibernate_active <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00);
      chk({2'b00, v, pins}, {36'h0_9001_0000, 3'b101});
      test_done;
   end
   initial
   begin
      repeat (5000) @(posedge aclk);
      failures = failures + 1;
      test_done;
   end
endmodule
